/* flags_cfg.svh */
// Offsets, field positions, reset values and timing counts for the
// status flag unit and the fetch sequencer.
// Assumes it is included by bare name from the core.
`ifndef FLAGS_CFG_SVH
`define FLAGS_CFG_SVH

// Bit positions inside the processor status byte.
`define ST_CARRY_BIT 0
`define ST_ZERO_BIT 1
`define ST_IRQ_OFF_BIT 2
`define ST_DECIMAL_BIT 3
`define ST_BREAK_BIT 4
`define ST_EXPAND_BIT 5
`define ST_OVERFLOW_BIT 6
`define ST_NEGATIVE_BIT 7

// Sign bit of an 8-bit operand or result.
`define SIGN_BIT 7

// Status byte after reset: only the expansion bit reads as one.
`define STATUS_RST 8'h20

// Program counter value after reset.
`define PC_RST 16'h0000

// Cycles from the read strobe until returned data leaves the synchroniser:
// one memory cycle plus two synchroniser stages.
`define MEM_LAT_CYCLES 4'h3

`endif

/* flags_pkg.sv */
// Types shared by the status flag unit, the fetch sequencer and the
// program counter halves.
// Assumes flags_cfg.svh is on the include path.
package flags_pkg;

  // Kind of operation whose result is offered to the flag unit.
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADD,
    OP_SUB,
    OP_MOVE,
    OP_BIT_TEST,
    OP_PULL_STATUS,
    OP_CLEAR_OVF
  } op_kind_t;

  // Steps of the timing-state counter.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_WAIT,
    ST_TAKE,
    ST_DECODE,
    ST_DONE
  } fetch_state_t;

  // Which byte of the instruction a fetch is taking.
  typedef enum logic [1:0] {
    PH_OPCODE,
    PH_LOW,
    PH_HIGH
  } fetch_phase_t;

endpackage : flags_pkg

/* pc_half.sv */
// One 8-bit half of the program counter, chained by its carry.
// Assumes a single clock; load wins over increment.
`timescale 1ns/1ps
`default_nettype none

module pc_half
  import flags_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  input wire logic clk, // Core clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic clk_en, // Freezes the half while low.
  input wire logic load, // Take load_val this cycle.
  input wire logic inc, // Count up by one.
  input wire logic [WIDTH-1:0] load_val, // Value to load.
  output logic [WIDTH-1:0] count, // Current half value.
  output logic carry_out // Increment rolls this half over.
);

  typedef struct packed {
    logic [WIDTH-1:0] value;
  } half_state_t;

  half_state_t s_reg;
  half_state_t s_next;

  // ----------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------
  // The carry is combinational so the upper half counts in the same
  // cycle; all ones plus one rolls over to zero by itself.
  always_comb
  begin
    s_next = s_reg;
    if (load)
    begin
      s_next.value = load_val;
    end
    else if (inc)
    begin
      s_next.value = s_reg.value + {{(WIDTH-1){1'b0}}, 1'b1}; // RULE15
    end
  end

  assign count = s_reg.value;
  assign carry_out = inc && !load && (s_reg.value == {WIDTH{1'b1}}); // RULE9

  // Register the state.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_reg.value <= RESET_VAL;
    end
    else if (clk_en)
    begin
      s_reg <= s_next;
    end
  end

endmodule : pc_half

`default_nettype wire

/* status_flags_and_pc_fetch.sv */
// Status flag unit and program counter fetch sequencer of an 8-bit core.
// Assumes byte-wide memory on the 16-bit address bus that answers a read
// strobe on the next edge, and an outside decode matrix on the same clock
// that reads the fetched opcode and answers within the decode step.
//
// What this block does
// (RULE1) Adding two non-negative operands whose sum has bit 7 set sets overflow.
// (RULE2) Adding two negative operands whose sum has bit 7 clear sets overflow.
// (RULE3) Operands of opposite sign never set overflow on add; on subtract they can.
// (RULE4) An add or subtract without overflow clears the overflow flag.
// (RULE5) Each result-producing operation copies result bit 7 into negative.
// (RULE6) No operation sets or clears the negative flag on its own.
// (RULE7) Only the listed result-producing operation kinds update negative.
// (RULE8) All flags are kept and shown together as one status byte.
// (RULE9) The program counter is two 8-bit halves acting as one counter.
// (RULE10) A 16-line address bus of upper and lower bytes selects a byte.
// (RULE11) The program counter keeps its full 16 bits internally.
// (RULE12) A fetch drives the counter onto the bus and decodes the data.
// (RULE13) The counter steps by one after every opcode or operand fetch.
// (RULE14) A timing-state counter and decode steer each clock cycle.
// (RULE15) Counting past the top address wraps to the bottom one.
// (RULE16) An absolute address takes its low byte first, then its high byte.
`timescale 1ns/1ps
`default_nettype none
`include "flags_cfg.svh"

module status_flags_and_pc_fetch
  import flags_pkg::*;
#(
  parameter int ADDR_WIDTH = 16,
  parameter int DATA_WIDTH = 8
)
(
  input wire logic clk, // Core clock, 200 MHz.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic clk_en, // Freezes all state while low.
  input wire logic start, // Leave idle and begin fetching.
  input wire logic [ADDR_WIDTH-1:0] start_addr, // First opcode address.
  input wire logic [DATA_WIDTH-1:0] mem_data, // Byte returned by memory.
  input wire logic [1:0] need_operands, // Operand bytes of the opcode.
  input wire logic jump_abs, // Opcode loads its operand into the counter.
  input wire op_kind_t op_kind, // Kind of datapath operation.
  input wire logic op_valid, // Operation result offered this cycle.
  input wire logic [DATA_WIDTH-1:0] operand_a, // First operand.
  input wire logic [DATA_WIDTH-1:0] operand_b, // Second operand.
  input wire logic [DATA_WIDTH-1:0] result, // Operation result.
  output logic [DATA_WIDTH-1:0] upper_addr_lines, // Address bits 15..8.
  output logic [DATA_WIDTH-1:0] lower_addr_lines, // Address bits 7..0.
  output logic mem_rd, // One-cycle read strobe.
  output logic [DATA_WIDTH-1:0] opcode, // Last fetched opcode.
  output logic [DATA_WIDTH-1:0] oper_low, // First operand byte.
  output logic [DATA_WIDTH-1:0] oper_high, // Second operand byte.
  output logic instr_done, // One-cycle pulse, instruction fetched.
  output logic [DATA_WIDTH-1:0] status // Processor status byte.
);

  typedef struct packed {
    fetch_state_t st;
    fetch_phase_t phase;
    logic [3:0] wait_cnt;
    logic [1:0] remaining;
    logic [DATA_WIDTH-1:0] addr_hi;
    logic [DATA_WIDTH-1:0] addr_lo;
    logic rd;
    logic [DATA_WIDTH-1:0] opc;
    logic [DATA_WIDTH-1:0] op_lo;
    logic [DATA_WIDTH-1:0] op_hi;
    logic done;
    logic [DATA_WIDTH-1:0] stat;
    logic [DATA_WIDTH-1:0] sync1;
    logic [DATA_WIDTH-1:0] sync2;
  } core_state_t;

  core_state_t s_reg;
  core_state_t s_next;

  logic pc_load;
  logic pc_inc;
  logic [ADDR_WIDTH-1:0] pc_load_val;
  logic [DATA_WIDTH-1:0] pc_lo;
  logic [DATA_WIDTH-1:0] pc_hi;
  logic lo_carry;
  logic [DATA_WIDTH-1:0] b_eff;
  logic ovf;

  // ----------------------------------------------------------------
  // Program counter halves
  // ----------------------------------------------------------------
  // The upper half counts on the carry of the lower half, so the pair
  // behaves as one 16-bit counter even if fewer pins leave the chip.
  pc_half #(
    .WIDTH(DATA_WIDTH),
    .RESET_VAL(DATA_WIDTH'(`PC_RST))
  ) u_pc_low (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .load(pc_load),
    .inc(pc_inc),
    .load_val(pc_load_val[DATA_WIDTH-1:0]),
    .count(pc_lo),
    .carry_out(lo_carry)
  );

  pc_half #(
    .WIDTH(DATA_WIDTH),
    .RESET_VAL(DATA_WIDTH'(`PC_RST >> DATA_WIDTH))
  ) u_pc_high (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .load(pc_load),
    .inc(lo_carry), // RULE9 RULE11
    .load_val(pc_load_val[ADDR_WIDTH-1:DATA_WIDTH]),
    .count(pc_hi),
    .carry_out()
  );

  // ----------------------------------------------------------------
  // Signed overflow
  // ----------------------------------------------------------------
  // Subtraction adds the inverted operand, so one sign test serves both.
  // On add, operands of opposite sign can never match the result test; on subtract they can.
  always_comb
  begin
    b_eff = (op_kind == OP_SUB) ? ~operand_b : operand_b;
    ovf = (operand_a[`SIGN_BIT] == b_eff[`SIGN_BIT]) && // RULE3
          (result[`SIGN_BIT] != operand_a[`SIGN_BIT]); // RULE1 RULE2
  end

  // ----------------------------------------------------------------
  // Timing-state counter and flag update
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.rd = 1'b0;
    s_next.done = 1'b0;
    s_next.sync1 = mem_data;
    s_next.sync2 = s_reg.sync1;
    pc_load = 1'b0;
    pc_inc = 1'b0;
    pc_load_val = start_addr;
    case (s_reg.st) // RULE14
      ST_IDLE:
      begin
        if (start)
        begin
          pc_load = 1'b1;
          s_next.phase = PH_OPCODE;
          s_next.st = ST_ISSUE;
        end
      end
      ST_ISSUE:
      begin
        s_next.addr_hi = pc_hi; // RULE10 RULE12
        s_next.addr_lo = pc_lo; // RULE10 RULE12
        s_next.rd = 1'b1;
        s_next.wait_cnt = `MEM_LAT_CYCLES;
        s_next.st = ST_WAIT;
      end
      ST_WAIT:
      begin
        // Data reaches the second synchroniser stage when this expires.
        s_next.wait_cnt = s_reg.wait_cnt - 4'h1;
        if (s_reg.wait_cnt == 4'h1)
        begin
          s_next.st = ST_TAKE;
        end
      end
      ST_TAKE:
      begin
        pc_inc = 1'b1; // RULE13 RULE11
        case (s_reg.phase)
          PH_OPCODE:
          begin
            s_next.opc = s_reg.sync2; // RULE12
            s_next.st = ST_DECODE;
          end
          PH_LOW:
          begin
            s_next.op_lo = s_reg.sync2; // RULE16
            s_next.phase = PH_HIGH;
            s_next.remaining = s_reg.remaining - 2'h1;
            s_next.st = (s_reg.remaining == 2'h1) ? ST_DONE : ST_ISSUE;
          end
          PH_HIGH:
          begin
            s_next.op_hi = s_reg.sync2; // RULE16
            s_next.remaining = 2'h0;
            s_next.st = ST_DONE;
          end
          default:
          begin
            s_next.st = ST_IDLE;
          end
        endcase
      end
      ST_DECODE:
      begin
        // The decode matrix sees the opcode register in this cycle.
        s_next.remaining = (need_operands > 2'h2) ? 2'h2 : need_operands;
        s_next.phase = PH_LOW;
        s_next.st = (need_operands == 2'h0) ? ST_DONE : ST_ISSUE;
      end
      ST_DONE:
      begin
        s_next.done = 1'b1;
        if (jump_abs)
        begin
          pc_load = 1'b1;
          pc_load_val = {s_reg.op_hi, s_reg.op_lo}; // RULE16
        end
        s_next.phase = PH_OPCODE;
        s_next.st = ST_ISSUE;
      end
      default:
      begin
        s_next.st = ST_IDLE;
      end
    endcase

    // There is deliberately no kind that only moves the negative flag.
    if (op_valid) // RULE6
    begin
      case (op_kind)
        OP_ADD, OP_SUB:
        begin
          s_next.stat[`ST_OVERFLOW_BIT] = ovf; // RULE4
          s_next.stat[`ST_NEGATIVE_BIT] = result[`SIGN_BIT]; // RULE5 RULE7
        end
        OP_MOVE:
        begin
          s_next.stat[`ST_NEGATIVE_BIT] = result[`SIGN_BIT]; // RULE5 RULE7
        end
        OP_BIT_TEST:
        begin
          // Bit test senses result bits 6 and 7 rather than a signed sum.
          s_next.stat[`ST_OVERFLOW_BIT] = result[`SIGN_BIT-1];
          s_next.stat[`ST_NEGATIVE_BIT] = result[`SIGN_BIT]; // RULE5 RULE7
        end
        OP_PULL_STATUS:
        begin
          s_next.stat = result; // RULE8 RULE7
        end
        OP_CLEAR_OVF:
        begin
          s_next.stat[`ST_OVERFLOW_BIT] = 1'b0;
        end
        default:
        begin
          s_next.stat = s_reg.stat;
        end
      endcase
    end
    // The expansion bit is not stored; it always reads as one.
    s_next.stat[`ST_EXPAND_BIT] = 1'b1;
  end

  // Register the state.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_reg <= '0;
      s_reg.stat <= `STATUS_RST;
    end
    else if (clk_en)
    begin
      s_reg <= s_next;
    end
  end

  assign upper_addr_lines = s_reg.addr_hi;
  assign lower_addr_lines = s_reg.addr_lo;
  assign mem_rd = s_reg.rd;
  assign opcode = s_reg.opc;
  assign oper_low = s_reg.op_lo;
  assign oper_high = s_reg.op_hi;
  assign instr_done = s_reg.done;
  assign status = s_reg.stat; // RULE8

endmodule : status_flags_and_pc_fetch

`default_nettype wire

/* status_flags_and_pc_fetch_properties.sv */
// Checker for the flag unit and the fetch sequencer ports.
// Assumes one clock domain with a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module flags_fetch_props
  import flags_pkg::*;
(
  input wire logic clk, // Core clock.
  input wire logic sys_rst, // Reset.
  input wire logic clk_en, // Run enable.
  input wire op_kind_t op_kind, // Kind.
  input wire logic op_valid, // Strobe.
  input wire logic [7:0] operand_a, // Operand.
  input wire logic [7:0] operand_b, // Operand.
  input wire logic [7:0] result, // Result.
  input wire logic [7:0] upper_addr_lines, // Address high.
  input wire logic [7:0] lower_addr_lines, // Address low.
  input wire logic mem_rd, // Read strobe.
  input wire logic instr_done, // Done pulse.
  input wire logic [7:0] status // Status byte.
);
  logic opc_reg;
  logic [15:0] last_reg;
  wire logic [15:0] adr = {upper_addr_lines, lower_addr_lines};
  wire logic go = op_valid && clk_en;
  wire logic add = go && op_kind == OP_ADD;
  // The read after a finished instruction is an opcode, not an operand.
  always_ff @(posedge clk)
  begin
    if (sys_rst || (clk_en && instr_done))
      opc_reg <= 1'b1;
    else if (clk_en && mem_rd)
      opc_reg <= 1'b0;
    if (clk_en && mem_rd)
      last_reg <= adr;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_OVF_POS: assert property (
    add && !operand_a[7] && !operand_b[7] && result[7] |=> status[6])
    else $error("positive overflow missed");
  AST_OVF_NEG: assert property (
    add && operand_a[7] && operand_b[7] && !result[7] |=> status[6])
    else $error("negative overflow missed");
  AST_OVF_MIX: assert property (
    add && (operand_a[7] != operand_b[7]) |=> !status[6])
    else $error("overflow on mixed signs");
  AST_NEG_COPY: assert property (
    go && op_kind inside {OP_ADD, OP_SUB, OP_MOVE, OP_BIT_TEST}
    |=> status[7] == $past(result[7])) else $error("negative not copied");
  AST_NEG_HOLD: assert property (
    !(go && op_kind inside {OP_ADD, OP_SUB, OP_MOVE, OP_BIT_TEST,
    OP_PULL_STATUS}) |=> $stable(status[7])) else $error("negative moved");
  AST_PULL: assert property (
    go && op_kind == OP_PULL_STATUS |=> status == ($past(result) | 8'h20))
    else $error("status not loaded whole");
  AST_RD_PULSE: assert property (
    mem_rd && clk_en |=> !mem_rd) else $error("read strobe too long");
  AST_ADDR_HOLD: assert property (
    $changed(adr) |-> mem_rd) else $error("address moved without read");
  AST_OPER_STEP: assert property (
    mem_rd && !opc_reg |-> adr == last_reg + 16'h0001)
    else $error("operand address not next");
  // Main scenarios: overflow, wrap of the counter, whole status load.
  cover property (add ##1 status[6]);
  cover property (mem_rd && !opc_reg && adr == 16'h0000);
  cover property (go && op_kind == OP_PULL_STATUS);
endmodule : flags_fetch_props
bind status_flags_and_pc_fetch flags_fetch_props i_flags_fetch_props (
  .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .op_kind(op_kind),
  .op_valid(op_valid), .operand_a(operand_a), .operand_b(operand_b),
  .result(result), .upper_addr_lines(upper_addr_lines),
  .lower_addr_lines(lower_addr_lines), .mem_rd(mem_rd),
  .instr_done(instr_done), .status(status));
`default_nettype wire

/* fetch_mem_model.sv */
// Byte-wide memory on the 16-bit address bus.
// Assumes the core's strobe and enable; each byte is a fixed function
// of its address so the bench can predict it.
`timescale 1ns/1ps
`default_nettype none
module fetch_mem_model
(
  input wire logic clk, // Core clock.
  input wire logic clk_en, // Core enable.
  input wire logic mem_rd, // Read strobe.
  input wire logic [15:0] addr, // Address lines.
  output logic [7:0] mem_data // Returned byte.
);
  logic [1:0] hold_reg;
  logic [7:0] held_reg;
  // Data is valid while the strobe stands and for two more edges, then
  // the lines toggle so a late sample never sees a stale byte.
  initial hold_reg = 2'h0;
  initial held_reg = 8'h00;
  always @(posedge clk)
  begin
    if (clk_en && mem_rd)
      hold_reg <= 2'h2;
    else if (clk_en && hold_reg != 2'h0)
      hold_reg <= hold_reg - 2'h1;
    if (clk_en && mem_rd)
      held_reg <= addr[7:0] ^ addr[15:8] ^ 8'h5A;
    else if (clk_en && hold_reg == 2'h0)
      held_reg <= ~held_reg;
  end
  assign mem_data = mem_rd ? addr[7:0] ^ addr[15:8] ^ 8'h5A : held_reg;
endmodule : fetch_mem_model
`default_nettype wire

/* status_flags_and_pc_fetch_tb.sv */
// Self-checking bench for the flag unit and fetch sequencer.
// Assumes the memory model byte is address low ^ high ^ 5A.
`timescale 1ns/1ps
`default_nettype none
module status_flags_and_pc_fetch_tb
  import flags_pkg::*;
;
  logic clk, sys_rst, clk_en, start, jump_abs, op_valid, rand_en;
  logic mem_rd, instr_done, fv_reg;
  logic [15:0] start_addr;
  logic [7:0] mem_data, operand_a, operand_b, result, opcode, status;
  logic [7:0] upper_addr_lines, lower_addr_lines, oper_low, oper_high;
  logic [1:0] need_operands;
  op_kind_t op_kind;
  int n_errors, check_count, cyc;
  logic [23:0] addr_q[$], ins_q[$], st_q[$];
  status_flags_and_pc_fetch i_status_flags_and_pc_fetch (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .start(start),
    .start_addr(start_addr), .mem_data(mem_data),
    .need_operands(need_operands), .jump_abs(jump_abs),
    .op_kind(op_kind), .op_valid(op_valid), .operand_a(operand_a),
    .operand_b(operand_b), .result(result),
    .upper_addr_lines(upper_addr_lines),
    .lower_addr_lines(lower_addr_lines), .mem_rd(mem_rd),
    .opcode(opcode), .oper_low(oper_low), .oper_high(oper_high),
    .instr_done(instr_done), .status(status));
  fetch_mem_model i_fetch_mem_model (.clk(clk), .clk_en(clk_en),
    .mem_rd(mem_rd), .addr({upper_addr_lines, lower_addr_lines}),
    .mem_data(mem_data));
  // ------
  // Clock, enable stalls and timeout
  // ------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Random stalls stretch the fetch walk; flag ops run unstalled.
  always @(posedge clk)
  begin
    clk_en <= !rand_en || ($urandom_range(0, 7) != 0);
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      final_report();
    end
  end
  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : mb
  task automatic report(string what, logic [23:0] exp, logic [23:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : report
  // One compare task per kind of result; all but check_drained read the live outputs.
  task automatic check_status(logic [23:0] exp);
    report("status", exp, {16'h0, status});
  endtask : check_status
  task automatic check_addr(logic [23:0] exp);
    report("address", exp, {8'h0, upper_addr_lines, lower_addr_lines});
  endtask : check_addr
  task automatic check_bytes(logic [23:0] exp);
    report("bytes", exp, {opcode, oper_low, oper_high});
  endtask : check_bytes
  task automatic check_drained(int left);
    report("pending", 24'h0, 24'(left));
  endtask : check_drained
  // Each result takes the oldest note of its kind off its queue.
  always @(posedge clk)
  begin
    fv_reg <= op_valid && clk_en;
    if (fv_reg && st_q.size() > 0)
      check_status(st_q.pop_front());
    if (clk_en && mem_rd && addr_q.size() > 0)
      check_addr(addr_q.pop_front());
    if (clk_en && instr_done && ins_q.size() > 0)
      check_bytes(ins_q.pop_front());
  end
  task automatic fetch_test();
    logic [15:0] pc;
    logic [7:0] lo, hi;
    logic j;
    int n;
    pc = 16'hFFFE;
    lo = 8'h00;
    hi = 8'h00;
    rand_en <= 1'b1;
    start_addr <= pc;
    start <= 1'b1;
    for (int i = 0; i < 14; i++)
    begin
      n = (i == 0) ? 2 : $urandom_range(0, 3);
      j = (n > 1) && (i % 3 == 1);
      need_operands <= 2'(n);
      jump_abs <= j;
      n = (n > 2) ? 2 : n;
      for (int k = 0; k <= n; k++)
        addr_q.push_back({8'h0, pc + 16'(k)});
      if (n > 0)
        lo = mb(pc + 16'h0001);
      if (n > 1)
        hi = mb(pc + 16'h0002);
      ins_q.push_back({mb(pc), lo, hi});
      pc = j ? {hi, lo} : pc + 16'(n + 1);
      do
        @(posedge clk);
      while (!(instr_done && clk_en));
      start <= 1'b0;
    end
    rand_en <= 1'b0;
    $display("fetch test done");
  endtask : fetch_test
  task automatic flag_test();
    logic [7:0] st, a, b, r;
    logic v;
    op_kind_t k;
    st = 8'h20;
    for (int i = 0; i < 80; i++)
    begin
      a = (i == 1) ? 8'h80 : $urandom;
      b = (i == 0) ? 8'h50 : (i == 1) ? 8'h80 : $urandom;
      a = (i == 0) ? 8'h50 : a;
      k = (i < 3) ? OP_ADD : op_kind_t'($urandom_range(0, 6));
      v = (i < 3) || ($urandom_range(0, 3) != 0);
      r = (k == OP_SUB) ? a - b : a + b;
      if (v && k inside {OP_ADD, OP_SUB, OP_MOVE, OP_BIT_TEST})
        st[7] = r[7];
      if (v && k == OP_ADD)
        st[6] = (a[7] == b[7]) && (r[7] != a[7]);
      if (v && k == OP_SUB)
        st[6] = (a[7] != b[7]) && (r[7] != a[7]);
      if (v && k == OP_BIT_TEST)
        st[6] = r[6];
      if (v && k == OP_CLEAR_OVF)
        st[6] = 1'b0;
      if (v && k == OP_PULL_STATUS)
        st = r | 8'h20;
      if (v)
        st_q.push_back({16'h0, st});
      @(posedge clk);
      op_valid <= v;
      op_kind <= k;
      operand_a <= a;
      operand_b <= b;
      result <= r;
    end
    @(posedge clk);
    op_valid <= 1'b0;
    $display("flag test done");
  endtask : flag_test
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  // Reset, then the fetch walk and the flag sequence.
  initial
  begin
    // Reset and enable high; no operation is offered until the flag test.
    {sys_rst, clk_en, start, jump_abs, op_valid, rand_en} = 6'h30;
    {start_addr, need_operands, operand_a, operand_b, result} = '0;
    op_kind = OP_NONE;
    {n_errors, check_count, cyc} = '0;
    void'($urandom(31660));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check_status(24'h20);
    fetch_test();
    flag_test();
    repeat (4) @(posedge clk);
    check_drained(addr_q.size() + ins_q.size() + st_q.size());
    final_report();
  end
endmodule : status_flags_and_pc_fetch_tb
`default_nettype wire
